// [src/irq_force_remap_defines.vh]
`ifndef IRQ_FORCE_REMAP_DEFINES_VH
`define IRQ_FORCE_REMAP_DEFINES_VH

// ----------------------------------------
// register offsets within the 64-byte space
// ----------------------------------------
`define OFS_FORCE_LEVEL_REQUESTS 6'h13
`define OFS_REMAP_SLOT_HIGH 6'h18
`define OFS_REMAP_SLOT_SECOND 6'h19
`define OFS_WAKEUP_CONTROL 6'h1B
`define OFS_FORCE_SET_PORT 6'h1E
`define OFS_FORCE_CLEAR_PORT 6'h1F

// ----------------------------------------
// field positions and limits
// ----------------------------------------
`define WAKEUP_ENABLE_BIT 7
`define WAKEUP_MASK_MAX 3'h6
`define REMAP_NUM_MIN 5'h02
`define REMAP_NUM_MAX 5'h1D
`define FORCE_PORT_MIN 8'h20
`define FORCE_PORT_MAX 8'h26
`define NUM_PERIPH_REQ 30
`define BUS_SIZE_BYTE 2'h0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_FORCE_LEVEL_REQUESTS 7'h00
`define RST_REMAP_SLOT 5'h00
`define RST_WAKEUP_ENABLE 1'h0
`define RST_WAKEUP_MASK 3'h0

`endif

// [src/irq_level_resolve.v]
`timescale 1ns/1ps
`include "irq_force_remap_defines.vh"

module irq_level_resolve (
    // peripheral and forced requests
    input wire [29:0] periph_req_in,
    input wire [6:0] force_bits_in,
    // remap selections
    input wire [4:0] remap_high_in,
    input wire [4:0] remap_second_in,
    // per-level activity and slot hits
    output reg [7:1] level_active_out,
    output wire high_hit_out,
    output wire second_hit_out
);

// ----------------------------------------
// fixed source level table
// ----------------------------------------
function [2:0] fixed_level;
    input [4:0] num;
    reg [4:0] band;
    begin
        band = (num - 5'h02) / 5'h05;
        if (num < 5'h02) begin
            fixed_level = 3'h7;
        end else if (band > 5'h04) begin
            fixed_level = 3'h1;
        end else begin
            fixed_level = 3'h6 - band[2:0];
        end
    end
endfunction

function remap_valid;
    input [4:0] num;
    begin
        remap_valid = (num >= `REMAP_NUM_MIN) && (num <= `REMAP_NUM_MAX);
    end
endfunction

// ----------------------------------------
// slot effectiveness
// ----------------------------------------
wire high_ok = remap_valid(remap_high_in);
wire second_ok = remap_valid(remap_second_in) &&
    !(high_ok && (remap_second_in == remap_high_in));

assign high_hit_out = high_ok && periph_req_in[remap_high_in];
assign second_hit_out = second_ok && periph_req_in[remap_second_in];

// ----------------------------------------
// level activity, remapped sources to level 6
// ----------------------------------------
integer i;
reg [2:0] lvl;
always @* begin
    level_active_out = 7'h00;
    lvl = 3'h0;
    for (i = 0; i < `NUM_PERIPH_REQ; i = i + 1) begin
        lvl = fixed_level(i[4:0]);
        if (i >= 2 && ((high_ok && remap_high_in == i[4:0]) ||
            (second_ok && remap_second_in == i[4:0]))) begin
            lvl = 3'h6;
        end
        if (periph_req_in[i]) begin
            level_active_out[lvl] = 1'b1;
        end
    end
    for (i = 0; i < 7; i = i + 1) begin
        if (force_bits_in[i]) begin
            level_active_out[7 - i] = 1'b1;
        end
    end
end

endmodule // irq_level_resolve

// [src/irq_force_remap_wakeup.v]
`timescale 1ns/1ps
`include "irq_force_remap_defines.vh"

module irq_force_remap_wakeup (
    // clock and reset
    input wire ref_clk_in,
    input wire rst_in,
    // peripheral byte bus
    input wire bus_sel_in,
    input wire bus_wr_in,
    input wire [1:0] bus_size_in,
    input wire [5:0] bus_addr_in,
    input wire [7:0] bus_wdata_in,
    output reg [7:0] bus_rdata_out,
    output reg bus_ack_out,
    output reg bus_err_out,
    // interrupt sources
    input wire [29:0] periph_req_in,
    // processor core side
    output reg [2:0] core_level_out,
    output reg remap_high_active_out,
    output reg remap_second_active_out,
    // clock generation side
    output wire wakeup_out
);

// ----------------------------------------
// register state
// ----------------------------------------
reg [6:0] force_ff;
reg [6:0] nxt_force;
reg [4:0] remap_high_ff;
reg [4:0] nxt_remap_high;
reg [4:0] remap_second_ff;
reg [4:0] nxt_remap_second;
reg wake_en_ff;
reg nxt_wake_en;
reg [2:0] wake_mask_ff;
reg [2:0] nxt_wake_mask;

// ----------------------------------------
// bus response state
// ----------------------------------------
reg [7:0] nxt_rdata;
reg nxt_ack;
reg nxt_err;

// ----------------------------------------
// helper functions
// ----------------------------------------
function [2:0] clamp_mask;
    input [2:0] val;
    begin
        if (val > `WAKEUP_MASK_MAX) begin
            clamp_mask = `WAKEUP_MASK_MAX;
        end else begin
            clamp_mask = val;
        end
    end
endfunction

function port_in_range;
    input [7:0] val;
    begin
        port_in_range = (val >= `FORCE_PORT_MIN) && (val <= `FORCE_PORT_MAX);
    end
endfunction

function [6:0] port_bit;
    input [7:0] val;
    reg [7:0] idx;
    begin
        idx = val - `FORCE_PORT_MIN;
        port_bit = 7'h01 << idx[2:0];
    end
endfunction

function [2:0] top_level;
    input [7:1] act;
    integer k;
    begin
        top_level = 3'h0;
        for (k = 1; k < 8; k = k + 1) begin
            if (act[k]) begin
                top_level = k[2:0];
            end
        end
    end
endfunction

// ----------------------------------------
// access decode
// ----------------------------------------
wire acc_byte = (bus_size_in == `BUS_SIZE_BYTE);
wire hit_force = (bus_addr_in == `OFS_FORCE_LEVEL_REQUESTS);
wire hit_high = (bus_addr_in == `OFS_REMAP_SLOT_HIGH);
wire hit_second = (bus_addr_in == `OFS_REMAP_SLOT_SECOND);
wire hit_wake = (bus_addr_in == `OFS_WAKEUP_CONTROL);
wire hit_set = (bus_addr_in == `OFS_FORCE_SET_PORT);
wire hit_clr = (bus_addr_in == `OFS_FORCE_CLEAR_PORT);
wire hit_rw = hit_force || hit_high || hit_second || hit_wake;
wire hit_wo = hit_set || hit_clr;

// a legal access is a byte read of a read/write register or a byte write
// of a read/write register or a set/clear port
wire acc_ok = acc_byte && (hit_rw || (hit_wo && bus_wr_in));
wire do_wr = bus_sel_in && acc_ok && bus_wr_in;
wire do_rd = bus_sel_in && acc_ok && !bus_wr_in;

// ----------------------------------------
// register next-state
// ----------------------------------------
always @* begin
    nxt_force = force_ff;
    nxt_remap_high = remap_high_ff;
    nxt_remap_second = remap_second_ff;
    nxt_wake_en = wake_en_ff;
    nxt_wake_mask = wake_mask_ff;
    if (do_wr) begin
        if (hit_force) begin
            // reserved bit 7 is not stored
            nxt_force = bus_wdata_in[6:0];
        end
        if (hit_set && port_in_range(bus_wdata_in)) begin
            nxt_force = force_ff | port_bit(bus_wdata_in);
        end
        if (hit_clr && port_in_range(bus_wdata_in)) begin
            nxt_force = force_ff & ~port_bit(bus_wdata_in);
        end
        if (hit_high) begin
            nxt_remap_high = bus_wdata_in[4:0];
        end
        if (hit_second) begin
            nxt_remap_second = bus_wdata_in[4:0];
        end
        if (hit_wake) begin
            nxt_wake_en = bus_wdata_in[`WAKEUP_ENABLE_BIT];
            nxt_wake_mask = clamp_mask(bus_wdata_in[2:0]);
        end
    end
end

// ----------------------------------------
// register storage
// ----------------------------------------
always @(posedge ref_clk_in) begin
    if (rst_in) begin
        force_ff <= `RST_FORCE_LEVEL_REQUESTS;
        remap_high_ff <= `RST_REMAP_SLOT;
        remap_second_ff <= `RST_REMAP_SLOT;
        wake_en_ff <= `RST_WAKEUP_ENABLE;
        wake_mask_ff <= `RST_WAKEUP_MASK;
    end else begin
        force_ff <= nxt_force;
        remap_high_ff <= nxt_remap_high;
        remap_second_ff <= nxt_remap_second;
        wake_en_ff <= nxt_wake_en;
        wake_mask_ff <= nxt_wake_mask;
    end
end

// ----------------------------------------
// read data and termination
// ----------------------------------------
always @* begin
    nxt_rdata = 8'h00;
    nxt_ack = 1'b0;
    nxt_err = 1'b0;
    if (bus_sel_in) begin
        if (acc_ok) begin
            nxt_ack = 1'b1;
        end else begin
            nxt_err = 1'b1;
        end
    end
    if (do_rd) begin
        if (hit_force) begin
            nxt_rdata = {1'b0, force_ff};
        end else if (hit_high) begin
            nxt_rdata = {3'h0, remap_high_ff};
        end else if (hit_second) begin
            nxt_rdata = {3'h0, remap_second_ff};
        end else begin
            nxt_rdata = {wake_en_ff, 4'h0, wake_mask_ff};
        end
    end
end

always @(posedge ref_clk_in) begin
    if (rst_in) begin
        bus_rdata_out <= 8'h00;
        bus_ack_out <= 1'b0;
        bus_err_out <= 1'b0;
    end else begin
        bus_rdata_out <= nxt_rdata;
        bus_ack_out <= nxt_ack;
        bus_err_out <= nxt_err;
    end
end

// ----------------------------------------
// level resolution
// ----------------------------------------
wire [7:1] level_active;
wire high_hit;
wire second_hit;

irq_level_resolve u_resolve (
    .periph_req_in(periph_req_in),
    .force_bits_in(force_ff),
    .remap_high_in(remap_high_ff),
    .remap_second_in(remap_second_ff),
    .level_active_out(level_active),
    .high_hit_out(high_hit),
    .second_hit_out(second_hit)
);

wire [2:0] req_level = top_level(level_active);

// ----------------------------------------
// encoded level to the core
// ----------------------------------------
always @(posedge ref_clk_in) begin
    if (rst_in) begin
        core_level_out <= 3'h0;
        remap_high_active_out <= 1'b0;
        remap_second_active_out <= 1'b0;
    end else begin
        core_level_out <= req_level;
        remap_high_active_out <= high_hit;
        remap_second_active_out <= second_hit;
    end
end

// ----------------------------------------
// wake-up path, no storage on the request side
// ----------------------------------------
// core status mask is expected to match wake_mask_ff
assign wakeup_out = wake_en_ff && (req_level > wake_mask_ff);

endmodule // irq_force_remap_wakeup

// [test/irq_frw_asserts.sv]
`timescale 1ns/1ps
// ----
// bus and core checks
// ----
module irq_frw_asserts (
    input wire ref_clk_in,
    input wire rst_in,
    input wire bus_sel_in,
    input wire bus_wr_in,
    input wire [1:0] bus_size_in,
    input wire [5:0] bus_addr_in,
    input wire [7:0] bus_rdata_out,
    input wire bus_ack_out,
    input wire bus_err_out,
    input wire [29:0] periph_req_in,
    input wire [2:0] core_level_out,
    input wire remap_high_active_out,
    input wire wakeup_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    sequence req_s;
        bus_sel_in;
    endsequence
    sequence bad_s;
        bus_sel_in && (bus_size_in != 2'h0 || (!bus_wr_in && bus_addr_in >= 6'h1E));
    endsequence
    sequence err_s;
        bus_err_out && !bus_ack_out;
    endsequence
    one_reply_a: assert property (req_s |=> bus_ack_out ^ bus_err_out)
        else $error("access without single reply");
    refuse_bad_a: assert property (bad_s |=> err_s)
        else $error("bad access not refused");
    no_reply_a: assert property (!bus_sel_in |=> !bus_ack_out && !bus_err_out)
        else $error("reply without access");
    rdata_idle_a: assert property (!bus_ack_out |-> bus_rdata_out == 8'h00)
        else $error("read data outside ack");
    reset_wake_a: assert property (disable iff (1'b0) rst_in |=> !wakeup_out)
        else $error("wake active after reset");
    level_seven_a: assert property (periph_req_in[1:0] != 2'h0 |=> core_level_out == 3'h7)
        else $error("level seven request moved");
    wake_cause_a: assert property ($rose(wakeup_out) |->
        bus_ack_out || periph_req_in != $past(periph_req_in))
        else $error("wake rose without cause");
    remap_level_a: assert property (remap_high_active_out |-> core_level_out >= 3'h6)
        else $error("remapped request below level six");
endmodule // irq_frw_asserts

bind irq_force_remap_wakeup irq_frw_asserts i_irq_frw_asserts (.ref_clk_in, .rst_in,
    .bus_sel_in, .bus_wr_in, .bus_size_in, .bus_addr_in, .bus_rdata_out, .bus_ack_out,
    .bus_err_out, .periph_req_in, .core_level_out, .remap_high_active_out, .wakeup_out);

// [test/core_clk_model.sv]
`timescale 1ns/1ps
// ----
// core and clock generation model
// ----
module core_clk_model (
    // clock and reset
    input wire ref_clk_in,
    input wire rst_in,
    // from the controller, and the core status mask
    input wire [2:0] level_in,
    input wire wake_in,
    input wire [2:0] status_mask_in,
    // observed state
    output reg irq_taken_out,
    output reg clocks_on_out
);
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            irq_taken_out <= 1'b0;
            clocks_on_out <= 1'b0;
        end else begin
            irq_taken_out <= (level_in > status_mask_in) || (level_in == 3'h7);
            clocks_on_out <= clocks_on_out | wake_in;
        end
    end
endmodule // core_clk_model

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
    reg ref_clk_in = 1'b0;
    reg rst_in = 1'b1;
    reg bus_sel_in = 1'b0;
    reg bus_wr_in = 1'b0;
    reg [1:0] bus_size_in = 2'h0;
    reg [5:0] bus_addr_in = 6'h00;
    reg [7:0] bus_wdata_in = 8'h00;
    reg [29:0] periph_req_in = 30'h0;
    reg [2:0] smask = 3'h0;
    wire [7:0] bus_rdata_out;
    wire [2:0] core_level_out;
    wire bus_ack_out, bus_err_out, wakeup_out, irq_taken, clocks_on;
    wire remap_high_active_out, remap_second_active_out;
    integer error_cnt = 0;
    integer num_checks = 0;
    integer cyc_cnt = 0;
    integer k;
    reg [7:0] got;
    reg [7:0] gerr;
    irq_force_remap_wakeup i_irq_force_remap_wakeup (.ref_clk_in, .rst_in, .bus_sel_in,
        .bus_wr_in, .bus_size_in, .bus_addr_in, .bus_wdata_in, .bus_rdata_out, .bus_ack_out,
        .bus_err_out, .periph_req_in, .core_level_out, .remap_high_active_out,
        .remap_second_active_out, .wakeup_out);
    core_clk_model i_core_clk_model (.ref_clk_in, .rst_in, .level_in(core_level_out),
        .wake_in(wakeup_out), .status_mask_in(smask), .irq_taken_out(irq_taken),
        .clocks_on_out(clocks_on));
    // ----
    // clock, timeout, tasks
    // ----
    initial begin
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        cyc_cnt = cyc_cnt + 1;
        if (cyc_cnt == 3000) begin
            error_cnt = error_cnt + 1;
            tally_and_finish;
        end
    end
    task tally_and_finish;
        begin
            if (error_cnt == 0 && num_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task chk(input [7:0] g, input [7:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task cyc;
        begin
            @(posedge ref_clk_in);
            #1;
        end
    endtask
    task acc(input w, input [1:0] s, input [5:0] a, input [7:0] d);
        begin
            bus_sel_in = 1'b1;
            bus_wr_in = w;
            bus_size_in = s;
            bus_addr_in = a;
            bus_wdata_in = d;
            cyc;
            got = bus_rdata_out;
            gerr = {7'h00, bus_err_out};
            bus_sel_in = 1'b0;
            cyc;
        end
    endtask
    task wr(input [5:0] a, input [7:0] d);
        begin
            acc(1'b1, 2'h0, a, d);
            chk(gerr, 8'h00);
        end
    endtask
    task rd(input [5:0] a, input [7:0] e);
        begin
            acc(1'b0, 2'h0, a, 8'h00);
            chk(gerr, 8'h00);
            chk(got, e);
        end
    endtask
    task bad(input w, input [1:0] s, input [5:0] a);
        begin
            acc(w, s, a, 8'h7F);
            chk(gerr, 8'h01);
        end
    endtask
    // ----
    // scenarios
    // ----
    initial begin
        repeat (4) @(posedge ref_clk_in);
        #1;
        rst_in = 1'b0;
        rd(6'h13, 8'h00);
        rd(6'h18, 8'h00);
        rd(6'h19, 8'h00);
        rd(6'h1B, 8'h00);
        wr(6'h13, 8'h7F);
        rd(6'h13, 8'h7F);
        for (k = 0; k < 7; k = k + 1) begin
            wr(6'h13, 8'h01 << k);
            chk({5'h00, core_level_out}, 8'h07 - k[7:0]);
        end
        wr(6'h13, 8'h00);
        chk({5'h00, core_level_out}, 8'h00);
        for (k = 0; k < 7; k = k + 1) begin
            wr(6'h1E, 8'h20 + k[7:0]);
            rd(6'h13, (8'h02 << k) - 8'h01);
        end
        wr(6'h1E, 8'h27);
        wr(6'h1F, 8'h1F);
        rd(6'h13, 8'h7F);
        for (k = 0; k < 7; k = k + 1) begin
            wr(6'h1F, 8'h20 + k[7:0]);
            rd(6'h13, 8'h7F & (8'hFE << k));
        end
        bad(1'b0, 2'h0, 6'h1E);
        bad(1'b0, 2'h0, 6'h1F);
        bad(1'b0, 2'h0, 6'h20);
        bad(1'b1, 2'h0, 6'h00);
        bad(1'b1, 2'h1, 6'h13);
        rd(6'h13, 8'h00);
        wr(6'h1B, 8'h87);
        rd(6'h1B, 8'h86);
        wr(6'h1B, 8'h83);
        smask = 3'h3;
        periph_req_in = 30'h1 << 12;
        #1;
        chk({7'h00, wakeup_out}, 8'h01);
        cyc;
        chk({5'h00, core_level_out}, 8'h04);
        periph_req_in = 30'h1 << 17;
        #1;
        chk({7'h00, wakeup_out}, 8'h00);
        cyc;
        periph_req_in = 30'h1 << 12;
        wr(6'h1B, 8'h03);
        chk({7'h00, wakeup_out}, 8'h00);
        wr(6'h1B, 8'h85);
        smask = 3'h5;
        periph_req_in = 30'h1 << 17;
        wr(6'h18, 8'h11);
        chk({5'h00, core_level_out}, 8'h06);
        chk({7'h00, remap_high_active_out}, 8'h01);
        chk({7'h00, wakeup_out}, 8'h01);
        cyc;
        chk({7'h00, irq_taken}, 8'h01);
        chk({7'h00, clocks_on}, 8'h01);
        periph_req_in = 30'h0;
        wr(6'h13, 8'h40);
        chk({5'h00, core_level_out}, 8'h01);
        wr(6'h13, 8'h00);
        periph_req_in = 30'h2;
        wr(6'h18, 8'h01);
        chk({5'h00, core_level_out}, 8'h07);
        chk({7'h00, remap_high_active_out}, 8'h00);
        periph_req_in = 30'h1 << 29;
        wr(6'h18, 8'h1E);
        chk({5'h00, core_level_out}, 8'h01);
        wr(6'h18, 8'h1D);
        chk({5'h00, core_level_out}, 8'h06);
        wr(6'h19, 8'h1D);
        chk({7'h00, remap_high_active_out}, 8'h01);
        chk({7'h00, remap_second_active_out}, 8'h00);
        wr(6'h18, 8'h00);
        chk({7'h00, remap_second_active_out}, 8'h01);
        chk({5'h00, core_level_out}, 8'h06);
        rst_in = 1'b1;
        cyc;
        cyc;
        rst_in = 1'b0;
        rd(6'h19, 8'h00);
        chk({7'h00, wakeup_out}, 8'h00);
        tally_and_finish;
    end
endmodule // tb
